/* logic/tcoc_apb_slave.sv */
// APB slave handshake and address decode for the compare-output control block.
`timescale 1ns/10ps

module tcoc_apb_slave
  import tcoc_pkg::*;
(
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // APB request
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  // Decoded strobes
  output logic             wr_stb,
  output logic             rd_stb,
  output logic [7:0]       acc_addr,
  output logic             pready,
  output logic             pslverr
);

  typedef struct packed
  {
    logic waited;
  } tcoc_apb_state_t;

  tcoc_apb_state_t state;
  tcoc_apb_state_t next_state;

  // One wait state: read data is captured on the first access edge, so it
  // already stands in its flip-flop when pready is high on the second.
  always_comb
  begin
    next_state        = state;
    next_state.waited = psel & penable & ~state.waited;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  function automatic logic tcoc_mapped(input logic [7:0] a);
    return (a == TCOC_ADDR_CTRL_A) || (a == TCOC_ADDR_CTRL_B) || (a == TCOC_ADDR_STATUS) ||
           (a == TCOC_ADDR_CMP_A) || (a == TCOC_ADDR_CMP_B) || (a == TCOC_ADDR_TOP);
  endfunction

  assign pready   = state.waited;
  assign acc_addr = paddr;
  assign wr_stb   = psel & penable & state.waited & pwrite & tcoc_mapped(paddr);
  assign rd_stb   = psel & penable & ~state.waited & ~pwrite;
  assign pslverr  = psel & penable & state.waited & ~tcoc_mapped(paddr);

endmodule

/* logic/tcoc_channel.sv */
// One compare-output channel: action decode and output flip-flop.
`timescale 1ns/10ps

module tcoc_channel
  import tcoc_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // Configuration
  input  wire logic [1:0]   output_action,
  input  wire logic [3:0]   waveform_mode_select,
  input  wire logic         is_chan_a,
  // Events
  input  wire logic         tick_match,
  input  wire logic         tick_bottom,
  input  wire logic         count_down,
  input  wire logic         cmp_is_top,
  input  wire logic         force_strobe,
  // Result
  output logic              compare_out,
  output logic              connected
);

  typedef struct packed
  {
    logic out;
  } tcoc_ch_state_t;

  tcoc_ch_state_t state;
  tcoc_ch_state_t next_state;
  tcoc_family_t   fam;
  logic           toggle_ok;
  logic           match_eff;

  assign fam = tcoc_family(waveform_mode_select);

  always_comb
  begin
    toggle_ok = 1'b0;
    unique case (fam)
      TCOC_FAM_NONPWM: toggle_ok = 1'b1;
      TCOC_FAM_FAST:   toggle_ok = is_chan_a && (waveform_mode_select == TCOC_WGM_FAST_OA);
      default:         toggle_ok = is_chan_a && (waveform_mode_select == TCOC_WGM_PFC_OCA ||
                                                 waveform_mode_select == TCOC_WGM_FAST_IC);
    endcase
  end

  assign connected = (output_action[1] | (output_action[0] & toggle_ok));

  // Fast PWM clear/set with compare at TOP: the match is dropped, BOTTOM does the work.
  assign match_eff = tick_match & ~((fam == TCOC_FAM_FAST) & cmp_is_top & output_action[1]);

  always_comb
  begin
    next_state = state;
    unique case (fam)
      TCOC_FAM_NONPWM:
      begin
        if (match_eff | force_strobe)
        begin
          unique case (output_action)
            2'b01:   next_state.out = ~state.out;
            2'b10:   next_state.out = 1'b0;
            2'b11:   next_state.out = 1'b1;
            default: next_state.out = state.out;
          endcase
        end
      end
      TCOC_FAM_FAST:
      begin
        if (output_action[1] & tick_bottom)
          next_state.out = ~output_action[0];
        else if (output_action[1] & match_eff)
          next_state.out = output_action[0];
        else if ((output_action == 2'b01) & toggle_ok & match_eff)
          next_state.out = ~state.out;
      end
      default:
      begin
        if (output_action[1] & match_eff)
          next_state.out = output_action[0] ^ count_down;
        else if ((output_action == 2'b01) & toggle_ok & match_eff)
          next_state.out = ~state.out;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state <= '0;
    else
      state <= next_state;
  end

  assign compare_out = state.out;

endmodule

/* logic/tcoc_pkg.sv */
// Package of register layout, mode codes and bus map for the compare-output control block.
package tcoc_pkg;

  // ==========================================================================
  // Register map (byte addresses on APB)
  localparam logic [7:0] TCOC_ADDR_CTRL_A   = 8'h00;
  localparam logic [7:0] TCOC_ADDR_CTRL_B   = 8'h04;
  localparam logic [7:0] TCOC_ADDR_STATUS   = 8'h08;
  localparam logic [7:0] TCOC_ADDR_CMP_A    = 8'h0c;
  localparam logic [7:0] TCOC_ADDR_CMP_B    = 8'h10;
  localparam logic [7:0] TCOC_ADDR_TOP      = 8'h14;

  // ==========================================================================
  // Field positions
  localparam int TCOC_A_ACT_HI   = 7;
  localparam int TCOC_A_ACT_LO   = 6;
  localparam int TCOC_B_ACT_HI   = 5;
  localparam int TCOC_B_ACT_LO   = 4;
  localparam int TCOC_FORCE_A    = 3;
  localparam int TCOC_FORCE_B    = 2;
  localparam int TCOC_WGM_LO_HI  = 1;
  localparam int TCOC_WGM_LO_LO  = 0;
  localparam int TCOC_WGM_HI_HI  = 4;
  localparam int TCOC_WGM_HI_LO  = 3;

  // ==========================================================================
  // Reset values
  localparam logic [7:0]  TCOC_CTRL_A_RST = 8'h00;
  localparam logic [7:0]  TCOC_CTRL_B_RST = 8'h00;
  localparam logic [15:0] TCOC_CMP_RST    = 16'h0000;
  localparam logic [15:0] TCOC_TOP_RST    = 16'hffff;
  localparam logic [15:0] TCOC_BOTTOM     = 16'h0000;

  // ==========================================================================
  // Mode codes
  localparam logic [3:0] TCOC_WGM_PFC_ICR = 4'h8;
  localparam logic [3:0] TCOC_WGM_PFC_OCA = 4'h9;
  localparam logic [3:0] TCOC_WGM_PC_OCA  = 4'hb;
  localparam logic [3:0] TCOC_WGM_FAST_IC = 4'he;
  localparam logic [3:0] TCOC_WGM_FAST_OA = 4'hf;

  typedef enum logic [1:0]
  {
    TCOC_FAM_NONPWM = 2'b00,
    TCOC_FAM_FAST   = 2'b01,
    TCOC_FAM_DUAL   = 2'b10,
    TCOC_FAM_PFC    = 2'b11
  } tcoc_family_t;

  typedef enum logic [2:0]
  {
    TCOC_ACT_NONE   = 3'b000,
    TCOC_ACT_TOGGLE = 3'b001,
    TCOC_ACT_CLEAR  = 3'b010,
    TCOC_ACT_SET    = 3'b011
  } tcoc_action_t;

  // Classify a four-bit waveform mode into its family.
  function automatic tcoc_family_t tcoc_family(input logic [3:0] wgm);
    tcoc_family_t f;
    f = TCOC_FAM_NONPWM;
    unique case (wgm)
      4'h1, 4'h2, 4'h3, 4'ha, 4'hb: f = TCOC_FAM_DUAL;
      4'h5, 4'h6, 4'h7, 4'he, 4'hf: f = TCOC_FAM_FAST;
      4'h8, 4'h9:                   f = TCOC_FAM_PFC;
      default:                      f = TCOC_FAM_NONPWM;
    endcase
    return f;
  endfunction

endpackage

/* logic/tcoc_top.sv */
// Top of the compare-output control block: registers, buffered compare values and pin override.
`timescale 1ns/10ps

module tcoc_top
  import tcoc_pkg::*;
(
  // Clock and reset
  input  wire logic         pclk,
  input  wire logic         presetn,
  // APB slave
  input  wire logic         psel,
  input  wire logic         penable,
  input  wire logic         pwrite,
  input  wire logic [7:0]   paddr,
  input  wire logic [31:0]  pwdata,
  output logic [31:0]       prdata,
  output logic              pready,
  output logic              pslverr,
  // Counter side
  input  wire logic         timer_tick_enable,
  input  wire logic [15:0]  counter_value,
  input  wire logic         count_down,
  // Port pin side
  input  wire logic         port_dir_a,
  input  wire logic         port_dir_b,
  input  wire logic         port_data_a,
  input  wire logic         port_data_b,
  output logic              pin_out_a,
  output logic              pin_oe_a,
  output logic              pin_out_b,
  output logic              pin_oe_b,
  // Match events to the timer flag logic
  output logic              compare_match_flag_a,
  output logic              compare_match_flag_b
);

  // ==========================================================================
  // State
  typedef struct packed
  {
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [15:0] cmp_buf_a;
    logic [15:0] cmp_buf_b;
    logic [15:0] cmp_a;
    logic [15:0] cmp_b;
    logic [15:0] top;
    logic        force_a;
    logic        force_b;
    logic        flag_a;
    logic        flag_b;
    logic [31:0] rdata;
  } tcoc_state_t;

  tcoc_state_t  state;
  tcoc_state_t  next_state;

  logic         wr_stb;
  logic         rd_stb;
  logic [7:0]   acc_addr;
  logic [3:0]   waveform_mode_select;
  tcoc_family_t fam;
  logic         at_bottom;
  logic         at_top;
  logic         match_a;
  logic         match_b;
  logic         out_a;
  logic         out_b;
  logic         conn_a;
  logic         conn_b;

  tcoc_apb_slave u_apb
  (
    .pclk     (pclk),
    .presetn  (presetn),
    .psel     (psel),
    .penable  (penable),
    .pwrite   (pwrite),
    .paddr    (paddr),
    .wr_stb   (wr_stb),
    .rd_stb   (rd_stb),
    .acc_addr (acc_addr),
    .pready   (pready),
    .pslverr  (pslverr)
  );

  // ==========================================================================
  // Mode decode
  assign waveform_mode_select = {state.ctrl_b[TCOC_WGM_HI_HI:TCOC_WGM_HI_LO],
                                 state.ctrl_a[TCOC_WGM_LO_HI:TCOC_WGM_LO_LO]};
  assign fam       = tcoc_family(waveform_mode_select);
  assign at_bottom = timer_tick_enable & (counter_value == TCOC_BOTTOM);
  assign at_top    = timer_tick_enable & (counter_value == state.top);
  // Matches, BOTTOM and TOP only count on a tick; registers and bus logic run every pclk edge.
  assign match_a   = timer_tick_enable & (counter_value == state.cmp_a);
  assign match_b   = timer_tick_enable & (counter_value == state.cmp_b);

  function automatic logic [31:0] tcoc_read(input tcoc_state_t s, input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    unique case (a)
      TCOC_ADDR_CTRL_A:
      begin
        v[7:0] = s.ctrl_a;
        v[TCOC_FORCE_A] = 1'b0;
        v[TCOC_FORCE_B] = 1'b0;
      end
      TCOC_ADDR_CTRL_B: v[7:0]  = s.ctrl_b;
      TCOC_ADDR_STATUS: v[3:0]  = {s.flag_b, s.flag_a, 2'b00};
      TCOC_ADDR_CMP_A:  v[15:0] = s.cmp_buf_a;
      TCOC_ADDR_CMP_B:  v[15:0] = s.cmp_buf_b;
      TCOC_ADDR_TOP:    v[15:0] = s.top;
      default:          v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  // ==========================================================================
  // Next state
  always_comb
  begin
    next_state         = state;
    next_state.force_a = 1'b0;
    next_state.force_b = 1'b0;
    // Flags come from real matches only, so a forced compare never raises one.
    next_state.flag_a  = match_a;
    next_state.flag_b  = match_b;

    if (wr_stb)
    begin
      unique case (acc_addr)
        TCOC_ADDR_CTRL_A:
        begin
          next_state.ctrl_a = pwdata[7:0];
          next_state.ctrl_a[TCOC_FORCE_A] = 1'b0;
          next_state.ctrl_a[TCOC_FORCE_B] = 1'b0;
          // Software is expected to write zero here in PWM modes; it is gated anyway.
          if (tcoc_family({state.ctrl_b[TCOC_WGM_HI_HI:TCOC_WGM_HI_LO],
                           pwdata[TCOC_WGM_LO_HI:TCOC_WGM_LO_LO]}) == TCOC_FAM_NONPWM)
          begin
            next_state.force_a = pwdata[TCOC_FORCE_A];
            next_state.force_b = pwdata[TCOC_FORCE_B];
          end
        end
        TCOC_ADDR_CTRL_B: next_state.ctrl_b    = pwdata[7:0];
        TCOC_ADDR_CMP_A:  next_state.cmp_buf_a = pwdata[15:0];
        TCOC_ADDR_CMP_B:  next_state.cmp_buf_b = pwdata[15:0];
        TCOC_ADDR_TOP:    next_state.top       = pwdata[15:0];
        default:          next_state.top       = state.top;
      endcase
    end

    // Compare update point depends on the family; non-PWM is immediate.
    unique case (fam)
      TCOC_FAM_NONPWM:
      begin
        next_state.cmp_a = next_state.cmp_buf_a;
        next_state.cmp_b = next_state.cmp_buf_b;
      end
      TCOC_FAM_DUAL:
      begin
        if (at_top)
        begin
          next_state.cmp_a = state.cmp_buf_a;
          next_state.cmp_b = state.cmp_buf_b;
        end
      end
      default:
      begin
        if (at_bottom)
        begin
          next_state.cmp_a = state.cmp_buf_a;
          next_state.cmp_b = state.cmp_buf_b;
        end
      end
    endcase

    if (rd_stb)
      next_state.rdata = tcoc_read(state, acc_addr);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state        <= '0;
      state.ctrl_a <= TCOC_CTRL_A_RST;
      state.ctrl_b <= TCOC_CTRL_B_RST;
      state.top    <= TCOC_TOP_RST;
    end
    else
      state <= next_state;
  end

  // ==========================================================================
  // Channels
  tcoc_channel u_chan_a
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .output_action        (state.ctrl_a[TCOC_A_ACT_HI:TCOC_A_ACT_LO]),
    .waveform_mode_select (waveform_mode_select),
    .is_chan_a            (1'b1),
    .tick_match           (match_a),
    .tick_bottom          (at_bottom),
    .count_down           (count_down),
    .cmp_is_top           (state.cmp_a == state.top),
    .force_strobe         (state.force_a),
    .compare_out          (out_a),
    .connected            (conn_a)
  );

  tcoc_channel u_chan_b
  (
    .pclk                 (pclk),
    .presetn              (presetn),
    .output_action        (state.ctrl_a[TCOC_B_ACT_HI:TCOC_B_ACT_LO]),
    .waveform_mode_select (waveform_mode_select),
    .is_chan_a            (1'b0),
    .tick_match           (match_b),
    .tick_bottom          (at_bottom),
    .count_down           (count_down),
    .cmp_is_top           (state.cmp_b == state.top),
    .force_strobe         (state.force_b),
    .compare_out          (out_b),
    .connected            (conn_b)
  );

  // ==========================================================================
  // Pin override
  assign pin_out_a = conn_a ? out_a : port_data_a;
  assign pin_out_b = conn_b ? out_b : port_data_b;
  assign pin_oe_a  = port_dir_a;
  assign pin_oe_b  = port_dir_b;

  assign prdata               = state.rdata;
  assign compare_match_flag_a = state.flag_a;
  assign compare_match_flag_b = state.flag_b;

endmodule

/* verif/tcoc_bench.sv */
// Self-checking bench for the compare-output control block.
`timescale 1ns/10ps

module tcoc_bench;
  import tcoc_pkg::*;
  logic        presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, timer_tick_enable = 1'b0;
  logic        count_down = 1'b0, port_dir_a = 1'b1, port_dir_b = 1'b1, port_data_a = 1'b0, port_data_b = 1'b0;
  logic        pclk, pready, pslverr, pin_out_a, pin_oe_a, pin_out_b, pin_oe_b, pad_a, pad_b, err, f, pa, pb;
  logic        compare_match_flag_a, compare_match_flag_b;
  logic [7:0]  paddr = 8'h00;
  logic [15:0] counter_value = 16'h0000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [1:0]  act [4] = '{2'h3, 2'h1, 2'h1, 2'h2};
  logic        fexp [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
  // Each row: second control byte, first control byte, A connected, B connected.
  logic [17:0] rows [9] = '{{8'h00, 8'h00, 2'b00}, {8'h00, 8'h50, 2'b11}, {8'h00, 8'hb0, 2'b11},
                            {8'h18, 8'h52, 2'b00}, {8'h18, 8'h53, 2'b10}, {8'h10, 8'h51, 2'b10},
                            {8'h10, 8'h50, 2'b00}, {8'h10, 8'h53, 2'b00}, {8'h00, 8'ha1, 2'b11}};
  int          n_fail, checked, cyc;

  tcoc_top dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .timer_tick_enable, .counter_value, .count_down, .port_dir_a, .port_dir_b, .port_data_a, .port_data_b,
    .pin_out_a, .pin_oe_a, .pin_out_b, .pin_oe_b, .compare_match_flag_a, .compare_match_flag_b);
  tcoc_pin_model pin_a (.pin_out(pin_out_a), .pin_oe(pin_oe_a), .pad(pad_a));
  tcoc_pin_model pin_b (.pin_out(pin_out_b), .pin_oe(pin_oe_b), .pad(pad_b));

  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end

  always @(posedge pclk)
  begin
    cyc++;
    if (cyc == 4000)
    begin
      n_fail++;
      end_of_test();
    end
  end

  // ==========================================================================
  // Tasks
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // The request stands until pready is seen high; data and response are taken at that edge.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    err = pslverr;
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask

  task automatic tk(input logic [15:0] c, input logic d);
    counter_value <= c;
    count_down <= d;
    timer_tick_enable <= 1'b1;
    @(posedge pclk);
    timer_tick_enable <= 1'b0;
    @(negedge pclk);
    f = compare_match_flag_a;
    @(negedge pclk);
    f = f | compare_match_flag_a;
    @(posedge pclk);
  endtask

  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // ==========================================================================
  // Sequence
  initial
  begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 9; i++)
    begin
      apb(1'b1, TCOC_ADDR_CTRL_B, {24'h0, rows[i][17:10]});
      apb(1'b1, TCOC_ADDR_CTRL_A, {24'h0, rows[i][9:2]});
      port_data_a <= 1'b1;
      port_data_b <= 1'b1;
      @(posedge pclk);
      pa = pad_a;
      pb = pad_b;
      port_data_a <= 1'b0;
      port_data_b <= 1'b0;
      @(posedge pclk);
      check("conn_a", {31'h0, pa === pad_a}, {31'h0, rows[i][1]});
      check("conn_b", {31'h0, pb === pad_b}, {31'h0, rows[i][0]});
    end
    $display("connection table done");
    apb(1'b1, TCOC_ADDR_CTRL_B, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, TCOC_ADDR_CTRL_A, {24'h0, act[i], act[i], 4'hc});
      @(negedge pclk);
      check("force_a", {31'h0, pad_a}, {31'h0, fexp[i]});
      check("force_b", {31'h0, pad_b}, {31'h0, fexp[i]});
      check("flags", {30'h0, compare_match_flag_a, compare_match_flag_b}, 32'h0);
      @(posedge pclk);
      apb(1'b0, TCOC_ADDR_CTRL_A, 32'h0);
      check("ctrl_a", rd, {24'h0, act[i], act[i], 4'h0});
    end
    $display("force test done");
    apb(1'b1, TCOC_ADDR_CMP_A, 32'h5);
    apb(1'b1, TCOC_ADDR_CTRL_A, 32'h40);
    counter_value <= 16'h0005;
    repeat (4) @(posedge pclk);
    check("no_tick", {31'h0, pad_a}, 32'h0);
    tk(16'h0005, 1'b0);
    check("tick_out", {31'h0, pad_a}, 32'h1);
    check("tick_flag", {31'h0, f}, 32'h1);
    tk(16'h0006, 1'b0);
    check("miss_out", {31'h0, pad_a}, 32'h1);
    $display("tick test done");
    // Mode 2, then mode 14 and mode 8: fast and dual-slope behaviour.
    apb(1'b1, TCOC_ADDR_CTRL_A, 32'h8a);
    @(negedge pclk);
    check("pwm_force", {31'h0, pad_a}, 32'h1);
    @(posedge pclk);
    apb(1'b1, TCOC_ADDR_CTRL_A, 32'h82);
    apb(1'b1, TCOC_ADDR_CTRL_B, 32'h18);
    apb(1'b1, TCOC_ADDR_CMP_A, 32'h64);
    tk(16'h0064, 1'b0);
    check("fast_buf", {31'h0, pad_a}, 32'h1);
    tk(16'h0000, 1'b0);
    tk(16'h0064, 1'b0);
    check("fast_clr", {31'h0, pad_a}, 32'h0);
    tk(16'h0000, 1'b0);
    check("fast_set", {31'h0, pad_a}, 32'h1);
    apb(1'b1, TCOC_ADDR_CMP_A, 32'hffff);
    apb(1'b1, TCOC_ADDR_CTRL_A, 32'hc2);
    tk(16'h0000, 1'b0);
    check("inv_bot", {31'h0, pad_a}, 32'h0);
    tk(16'hffff, 1'b0);
    check("top_match", {31'h0, pad_a}, 32'h0);
    $display("fast test done");
    apb(1'b1, TCOC_ADDR_CTRL_B, 32'h10);
    apb(1'b1, TCOC_ADDR_CTRL_A, 32'h80);
    apb(1'b1, TCOC_ADDR_CMP_A, 32'h32);
    tk(16'h0000, 1'b0);
    tk(16'h0032, 1'b1);
    check("down_set", {31'h0, pad_a}, 32'h1);
    apb(1'b1, TCOC_ADDR_CMP_A, 32'h3c);
    tk(16'h0032, 1'b0);
    check("up_clr", {31'h0, pad_a}, 32'h0);
    check("pfc_flag", {31'h0, f}, 32'h1);
    $display("dual-slope test done");
    port_dir_a <= 1'b0;
    @(posedge pclk);
    check("oe_off", {30'h0, pin_oe_a, pad_a}, 32'h1);
    port_dir_a <= 1'b1;
    apb(1'b0, 8'h20, 32'h0);
    check("unmapped", {rd[30:0], err}, 32'h1);
    port_data_a <= 1'b1;
    presetn <= 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    apb(1'b0, TCOC_ADDR_CTRL_A, 32'h0);
    check("rst_ctrl_a", rd, 32'h0);
    apb(1'b0, TCOC_ADDR_TOP, 32'h0);
    check("rst_top", rd, 32'h0000ffff);
    check("rst_pin", {31'h0, pad_a}, 32'h1);
    $display("reset test done");
    end_of_test();
  end
endmodule

/* verif/tcoc_pin_model.sv */
// Behavioural model of the port pad that a compare output drives.
`timescale 1ns/10ps

module tcoc_pin_model
(
  // Driver from the block
  input  wire logic pin_out,
  input  wire logic pin_oe,
  // Pad level seen outside
  output logic      pad
);
  // A released pad is pulled high, so a stale driven level never lingers.
  assign pad = pin_oe ? pin_out : 1'b1;
endmodule

/* verif/tcoc_properties.sv */
// Concurrent checks on the ports of the compare-output control top.
`timescale 1ns/10ps

module tcoc_properties
  import tcoc_pkg::*;
(
  // Clock and reset
  input wire logic        pclk,
  input wire logic        presetn,
  // APB
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // Counter and pins
  input wire logic        timer_tick_enable,
  input wire logic        port_dir_a,
  input wire logic        port_dir_b,
  input wire logic        port_data_a,
  input wire logic        pin_out_a,
  input wire logic        pin_oe_a,
  input wire logic        pin_oe_b,
  // Match events
  input wire logic        compare_match_flag_a,
  input wire logic        compare_match_flag_b
);
  logic acc;
  logic mapped;

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  assign acc    = psel && penable;
  assign mapped = paddr inside {TCOC_ADDR_CTRL_A, TCOC_ADDR_CTRL_B, TCOC_ADDR_STATUS, TCOC_ADDR_CMP_A,
                                TCOC_ADDR_CMP_B, TCOC_ADDR_TOP};

  // ==========================================================================
  // Sequences
  // No tick and no bus request; after two such cycles nothing can move a compare output.
  sequence quiet_s;
    !timer_tick_enable && !psel;
  endsequence
  sequence quiet_two_s;
    quiet_s ##1 quiet_s;
  endsequence

  // ==========================================================================
  // Properties
  oe_a_follow_a: assert property (pin_oe_a == port_dir_a)
    else $error("pin A enable differs from direction");
  oe_b_follow_a: assert property (pin_oe_b == port_dir_b)
    else $error("pin B enable differs from direction");
  ready_access_a: assert property (acc && !pready |=> pready)
    else $error("pready not high after one wait state");
  slverr_map_a: assert property (acc && pready |-> pslverr == !mapped)
    else $error("pslverr wrong for address");
  force_zero_a: assert property (acc && pready && !pwrite && paddr == TCOC_ADDR_CTRL_A |-> prdata[3:2] == 2'b00)
    else $error("force bits read nonzero");
  flag_pulse_a: assert property (compare_match_flag_a |=> !compare_match_flag_a)
    else $error("match flag A longer than one cycle");
  flag_a_tick_a: assert property (compare_match_flag_a |-> $past(timer_tick_enable) || $past(timer_tick_enable, 2))
    else $error("match flag A without tick");
  flag_b_tick_a: assert property (compare_match_flag_b |-> $past(timer_tick_enable) || $past(timer_tick_enable, 2))
    else $error("match flag B without tick");
  pin_hold_a: assert property (quiet_two_s ##1 $stable(port_data_a) |-> $stable(pin_out_a))
    else $error("pin A moved with no cause");
  rdata_hold_a: assert property (!(acc && !pwrite) |=> $stable(prdata))
    else $error("read data changed without read");
endmodule

bind tcoc_top tcoc_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .prdata, .pready,
  .pslverr, .timer_tick_enable, .port_dir_a, .port_dir_b, .port_data_a, .pin_out_a, .pin_oe_a, .pin_oe_b,
  .compare_match_flag_a, .compare_match_flag_b);
